// *** rtl/iolpc_pkg.sv ***
package iolpc_pkg;

   // Register address and reset value of the write-only option register.
   localparam logic [7:0] IOLPC_OPT_ADDR  = 8'hC8;
   localparam logic [7:0] IOLPC_OPT_RESET = 8'h00;

   // Field positions inside the option register.
   localparam int IOLPC_BIT_V1_LEVEL = 6;
   localparam int IOLPC_BIT_V2_EDGE  = 5;
   localparam int IOLPC_BIT_GEN      = 4;

   // Vector addresses (low byte of each vector pair).
   localparam logic [11:0] IOLPC_VEC_RESET = 12'hFFE;
   localparam logic [11:0] IOLPC_VEC_NMI   = 12'hFFC;
   localparam logic [11:0] IOLPC_VEC_EXT1  = 12'hFF6;
   localparam logic [11:0] IOLPC_VEC_EXT2  = 12'hFF4;
   localparam logic [11:0] IOLPC_VEC_TIMER = 12'hFF2;
   localparam logic [11:0] IOLPC_VEC_CONV  = 12'hFF0;

   // Oscillator start-up delays, in internal clock cycles.
   localparam logic [15:0] IOLPC_START_SHORT = 16'h0800;
   localparam logic [15:0] IOLPC_START_LONG  = 16'h8000;

   // Power modes.
   typedef enum logic [1:0] {
      IOLPC_RUN,
      IOLPC_WAIT,
      IOLPC_STOP,
      IOLPC_START
   } iolpc_mode_t;

endpackage

// *** rtl/iolpc_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for a group of pin inputs.
module iolpc_sync #(
   parameter int W = 1
) (
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         rst,
   // Raw pins and their synchronised copy.
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   // State: first and second stage.
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } iolpc_sync_t;

   iolpc_sync_t st;
   iolpc_sync_t next_st;

   // The first stage feeds only the second stage.
   always_comb begin
      next_st    = st;
      next_st.s1 = d;
      next_st.s2 = st.s1;
   end

   // Pins idle high (pull-ups), so reset to ones to avoid a false edge.
   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '1;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.s2;

endmodule
`default_nettype wire

// *** rtl/iolpc_start.sv ***
`timescale 1ns/1ps
`default_nettype none
// Oscillator start-up delay counter; done pulses when the count expires.
module iolpc_start (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rst,
   // Start request and chosen length.
   input  wire logic        start,
   input  wire logic        long_sel,
   // One-cycle pulse when the delay is over.
   output logic             done
);

   // State: remaining count, busy flag and done pulse.
   typedef struct packed {
      logic [15:0] cnt;
      logic        busy;
      logic        done;
   } iolpc_start_t;

   iolpc_start_t st;
   iolpc_start_t next_st;

   // Load on start, count down, pulse done on the last cycle.
   always_comb begin
      next_st      = st;
      next_st.done = 1'b0;
      if (start) begin
         next_st.busy = 1'b1;
         next_st.cnt  = long_sel ? iolpc_pkg::IOLPC_START_LONG - 16'h0001
                                 : iolpc_pkg::IOLPC_START_SHORT - 16'h0001;
      end else if (st.busy) begin
         if (st.cnt == 16'h0000) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
         end else begin
            next_st.cnt = st.cnt - 16'h0001;
         end
      end
   end

   // Registered state.
   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign done = st.done;

endmodule
`default_nettype wire

// *** rtl/iolpc_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Option register at C8h, write-only, resets 00h.
// - Bit 6: vector 1 falling edge or level.
// - Bit 5: vector 2 falling or rising.
// - Bit 4 globally enables maskable requests.
// - NMI served but no wake when disabled.
// - Ext vectors FF6h and FF4h wake STOP.
// - Reset leaves device running on main oscillator.
// - WAIT halts core, keeps oscillator running.
// - WAIT and STOP keep RAM and registers.
// - WAIT ends on reset or any interrupt; here NMI ends it only while bit 4 is set.
// - STOP halts core and stops oscillator.
// - STOP ends on reset, external, timer interrupt.
// - STOP exit waits 2048 or 32768 cycles.
// - After delay, vector of waking source loads.
// - Watchdog active: STOP becomes WAIT unless allowed.
// - Allowed STOP freezes the watchdog counter.
// - Fixed priority, one at a time, no preemption; here NMI still preempts a maskable routine.
// - Edge latch holds first edge, cleared on entry.
// - WAIT or STOP ignored with enabled request pending.
// - NMI falling edge latched, cleared on entry.
module iolpc_ctrl (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rst,
   // Core data-space write port.
   input  wire logic        wr_en,
   input  wire logic [7:0]  wr_addr,
   input  wire logic [7:0]  wr_data,
   // Core instruction and sequencing.
   input  wire logic        exec_wait,
   input  wire logic        exec_stop,
   input  wire logic        vector_ack,
   input  wire logic        reti,
   // Interrupt pins (asynchronous).
   input  wire logic        nmi_pin_n,
   input  wire logic        port_a_irq_n,
   input  wire logic        port_bc_irq,
   // Peripheral flags, already on this clock.
   input  wire logic        timer_zero_flag,
   input  wire logic        timer_irq_en,
   input  wire logic        conv_done_flag,
   input  wire logic        conv_irq_en,
   // Watchdog and option state.
   input  wire logic        watchdog_active,
   input  wire logic        stop_with_watchdog_option,
   input  wire logic        backup_low_freq_osc,
   input  wire logic        long_start_sel,
   // Outputs to the core and clock tree.
   output logic             irq_req,
   output logic [11:0]      irq_vector,
   output logic             core_halt,
   output logic             osc_enable,
   output logic             periph_clk_en,
   output logic             watchdog_freeze,
   output logic             use_backup_osc,
   output logic [1:0]       power_mode
);

   // Synchronised pin levels and the start-up done pulse.
   logic nmi_s;
   logic pa_s;
   logic pbc_s;
   logic start_done;

   // All block state in one record.
   typedef struct packed {
      logic [7:0]            opt;
      logic                  nmi_prev;
      logic                  pbc_prev;
      logic                  pa_prev;
      logic                  nmi_latch;
      logic                  v1_latch;
      logic                  v2_latch;
      logic                  in_nmi;
      logic                  in_irq;
      iolpc_pkg::iolpc_mode_t mode;
      logic                  start_go;
      logic                  irq_req;
      logic [11:0]           irq_vector;
      logic                  core_halt;
      logic                  osc_enable;
      logic                  periph_clk_en;
      logic                  wd_freeze;
      logic                  backup;
   } iolpc_ctrl_t;

   iolpc_ctrl_t st;
   iolpc_ctrl_t next_st;

   // Pins cross two flip-flops before any logic looks at them.
   iolpc_sync #(.W(3)) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({nmi_pin_n, port_a_irq_n, port_bc_irq}),
      .q   ({nmi_s, pa_s, pbc_s})
   );

   // Start-up delay after STOP.
   iolpc_start u_start (
      .clk      (clk),
      .rst      (rst),
      .start    (st.start_go),
      .long_sel (long_start_sel),
      .done     (start_done)
   );

   // Combinational views of configuration and pending sources.
   logic gen;
   logic v1_level;
   logic v2_rise;
   logic v1_pend;
   logic v2_pend;
   logic tm_pend;
   logic cv_pend;
   logic mask_pend;
   logic nmi_fall;
   logic v1_edge;
   logic v2_edge;
   logic stop_wake;
   logic wait_wake;

   always_comb begin
      gen      = st.opt[iolpc_pkg::IOLPC_BIT_GEN];
      v1_level = st.opt[iolpc_pkg::IOLPC_BIT_V1_LEVEL];
      v2_rise  = st.opt[iolpc_pkg::IOLPC_BIT_V2_EDGE];
      nmi_fall = st.nmi_prev & ~nmi_s;
      v1_edge  = st.pa_prev & ~pa_s;
      v2_edge  = v2_rise ? (~st.pbc_prev & pbc_s) : (st.pbc_prev & ~pbc_s);
      // Level mode is not stored: the pin must still be low when sampled.
      v1_pend  = v1_level ? ~pa_s : st.v1_latch;
      v2_pend  = st.v2_latch;
      tm_pend  = timer_zero_flag & timer_irq_en;
      cv_pend  = conv_done_flag & conv_irq_en;
      mask_pend = gen & (v1_pend | v2_pend | tm_pend | cv_pend);
      // NMI only wakes when the global enable is set.
      stop_wake = (gen & (v1_pend | v2_pend | tm_pend)) | (gen & st.nmi_latch);
      wait_wake = mask_pend | (gen & st.nmi_latch);
   end

   // Next-state logic.
   always_comb begin
      next_st          = st;
      next_st.start_go = 1'b0;
      next_st.irq_req  = 1'b0;
      next_st.nmi_prev = nmi_s;
      next_st.pa_prev  = pa_s;
      next_st.pbc_prev = pbc_s;

      // Whole-byte write only; the register has no read path.
      if (wr_en && (wr_addr == iolpc_pkg::IOLPC_OPT_ADDR)) begin
         next_st.opt = wr_data;
      end

      // Edge latches: set wins over clear, only the first edge is held.
      if (nmi_fall) begin
         next_st.nmi_latch = 1'b1;
      end
      if (!v1_level && v1_edge) begin
         next_st.v1_latch = 1'b1;
      end
      if (v2_edge) begin
         next_st.v2_latch = 1'b1;
      end

      // Return from a routine reopens the priority window.
      if (reti) begin
         if (st.in_nmi) begin
            next_st.in_nmi = 1'b0;
         end else begin
            next_st.in_irq = 1'b0;
         end
      end

      case (st.mode)
         iolpc_pkg::IOLPC_RUN: begin
            // Vector issue: NMI first, then fixed order 1..4.
            // Nothing is issued on the acknowledge edge: the routine is not yet
            // marked, and a pulse there would read as a second request.
            if (st.nmi_latch && !st.in_nmi && !st.irq_req && !vector_ack) begin
               next_st.irq_req    = 1'b1;
               next_st.irq_vector = iolpc_pkg::IOLPC_VEC_NMI;
            end else if (mask_pend && !st.in_irq && !st.in_nmi && !st.irq_req
                         && !vector_ack) begin
               next_st.irq_req = 1'b1;
               if (v1_pend) begin
                  next_st.irq_vector = iolpc_pkg::IOLPC_VEC_EXT1;
               end else if (v2_pend) begin
                  next_st.irq_vector = iolpc_pkg::IOLPC_VEC_EXT2;
               end else if (tm_pend) begin
                  next_st.irq_vector = iolpc_pkg::IOLPC_VEC_TIMER;
               end else begin
                  next_st.irq_vector = iolpc_pkg::IOLPC_VEC_CONV;
               end
            end
            // Instructions are dropped while an enabled request waits.
            if ((exec_wait || exec_stop) && !mask_pend && !st.nmi_latch) begin
               next_st.core_halt = 1'b1;
               if (exec_stop && (!watchdog_active ||
                   (stop_with_watchdog_option && nmi_s))) begin
                  next_st.mode          = iolpc_pkg::IOLPC_STOP;
                  next_st.osc_enable    = 1'b0;
                  next_st.periph_clk_en = 1'b0;
                  next_st.wd_freeze     = watchdog_active;
               end else begin
                  // Oscillator keeps running so peripherals stay clocked.
                  next_st.mode = iolpc_pkg::IOLPC_WAIT;
               end
            end
         end
         iolpc_pkg::IOLPC_WAIT: begin
            if (wait_wake) begin
               next_st.mode      = iolpc_pkg::IOLPC_RUN;
               next_st.core_halt = 1'b0;
            end
         end
         iolpc_pkg::IOLPC_STOP: begin
            if (stop_wake) begin
               next_st.mode       = iolpc_pkg::IOLPC_START;
               next_st.osc_enable = 1'b1;
               next_st.start_go   = 1'b1;
            end
         end
         iolpc_pkg::IOLPC_START: begin
            // Core resumes only when the oscillator is trusted.
            if (start_done) begin
               next_st.mode          = iolpc_pkg::IOLPC_RUN;
               next_st.core_halt     = 1'b0;
               next_st.periph_clk_en = 1'b1;
               next_st.wd_freeze     = 1'b0;
            end
         end
         default: begin
            next_st.mode = iolpc_pkg::IOLPC_RUN;
         end
      endcase

      // Vector taken by the core: clear its latch and mark the routine.
      if (vector_ack) begin
         if (st.irq_vector == iolpc_pkg::IOLPC_VEC_NMI) begin
            next_st.nmi_latch = nmi_fall;
            next_st.in_nmi    = 1'b1;
         end else begin
            next_st.in_irq = 1'b1;
            if (st.irq_vector == iolpc_pkg::IOLPC_VEC_EXT1) begin
               next_st.v1_latch = !v1_level && v1_edge;
            end
            if (st.irq_vector == iolpc_pkg::IOLPC_VEC_EXT2) begin
               next_st.v2_latch = v2_edge;
            end
         end
      end

      // Backup oscillator follows software only while running.
      if (st.mode == iolpc_pkg::IOLPC_RUN) begin
         next_st.backup = backup_low_freq_osc;
      end
   end

   // Reset gives RUN on the main oscillator; RAM is not touched here.
   always_ff @(posedge clk) begin
      if (rst) begin
         st               <= '0;
         st.opt           <= iolpc_pkg::IOLPC_OPT_RESET;
         st.nmi_prev      <= 1'b1;
         st.pa_prev       <= 1'b1;
         st.pbc_prev      <= 1'b1;
         st.mode          <= iolpc_pkg::IOLPC_RUN;
         st.irq_vector    <= iolpc_pkg::IOLPC_VEC_RESET;
         st.osc_enable    <= 1'b1;
         st.periph_clk_en <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from flip-flops.
   assign irq_req         = st.irq_req;
   assign irq_vector      = st.irq_vector;
   assign core_halt       = st.core_halt;
   assign osc_enable      = st.osc_enable;
   assign periph_clk_en   = st.periph_clk_en;
   assign watchdog_freeze = st.wd_freeze;
   assign use_backup_osc  = st.backup;
   assign power_mode      = st.mode;

   // Checks.
   gen_block_a: assert property (@(posedge clk) disable iff (rst)
      (irq_req && irq_vector != iolpc_pkg::IOLPC_VEC_NMI) |-> $past(gen))
      else $error("maskable vector issued while disabled");
   stop_osc_a: assert property (@(posedge clk) disable iff (rst)
      (power_mode == iolpc_pkg::IOLPC_STOP) |-> !osc_enable)
      else $error("oscillator running in stop");
   wait_osc_a: assert property (@(posedge clk) disable iff (rst)
      (power_mode == iolpc_pkg::IOLPC_WAIT) |-> (osc_enable && core_halt))
      else $error("wait mode wrong clocks");
   start_hold_a: assert property (@(posedge clk) disable iff (rst)
      $rose(power_mode == iolpc_pkg::IOLPC_START) |-> core_halt [*8])
      else $error("core resumed early after stop");
   wd_freeze_a: assert property (@(posedge clk) disable iff (rst)
      watchdog_freeze |-> (power_mode != iolpc_pkg::IOLPC_RUN))
      else $error("watchdog frozen while running");
   pend_block_a: assert property (@(posedge clk) disable iff (rst)
      (power_mode == iolpc_pkg::IOLPC_RUN && mask_pend) |=> power_mode == iolpc_pkg::IOLPC_RUN)
      else $error("low power entered with pending request");
   nmi_nowake_a: assert property (@(posedge clk) disable iff (rst)
      (power_mode == iolpc_pkg::IOLPC_WAIT && !gen) |=> power_mode == iolpc_pkg::IOLPC_WAIT)
      else $error("woke while globally disabled");
   one_at_a: assert property (@(posedge clk) disable iff (rst)
      (st.in_irq && irq_req) |-> irq_vector == iolpc_pkg::IOLPC_VEC_NMI)
      else $error("maskable routine preempted");
   cv_wait_c: cover property (@(posedge clk) power_mode == iolpc_pkg::IOLPC_WAIT);
   cv_stop_c: cover property (@(posedge clk) $fell(power_mode == iolpc_pkg::IOLPC_START));
   cv_nmi_c: cover property (@(posedge clk) irq_req && irq_vector == iolpc_pkg::IOLPC_VEC_NMI);
   // Level mode on vector 1 asking for service.
   cv_level_c: cover property (@(posedge clk)
      irq_req && v1_level && irq_vector == iolpc_pkg::IOLPC_VEC_EXT1);

   // A falling NMI edge is held until the core takes it, whatever the enable.
   nmi_latch_a: assert property (@(posedge clk) disable iff (rst)
      nmi_fall |=> st.nmi_latch)
      else $error("nmi edge not latched");

   // Without permission a STOP under a running watchdog must land in WAIT.
   // The oscillator is kept, since the watchdog still needs its clock.
   stop_as_wait_a: assert property (@(posedge clk) disable iff (rst)
      (power_mode == iolpc_pkg::IOLPC_RUN && exec_stop && watchdog_active &&
       !stop_with_watchdog_option && !mask_pend && !st.nmi_latch)
      |=> (power_mode == iolpc_pkg::IOLPC_WAIT && osc_enable))
      else $error("stop taken with watchdog running");

   // When the start-up count expires the core resumes on a running clock tree.
   start_exit_a: assert property (@(posedge clk) disable iff (rst)
      (power_mode == iolpc_pkg::IOLPC_START && start_done)
      |=> (power_mode == iolpc_pkg::IOLPC_RUN && !core_halt &&
           periph_clk_en && !watchdog_freeze))
      else $error("no clean resume after start-up");

   // Taking vector 1 drops its latch unless a fresh edge arrives that cycle.
   v1_clear_a: assert property (@(posedge clk) disable iff (rst)
      (vector_ack && irq_vector == iolpc_pkg::IOLPC_VEC_EXT1 && !v1_edge) |=> !st.v1_latch)
      else $error("vector 1 latch kept after service");

endmodule
`default_nettype wire

// *** verif/iolpc_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Core stand-in: takes a request, acknowledges it, runs a short routine, returns.
module iolpc_core_model (
   // Clock, reset and pace.
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic slow,
   // Handshake with the controller.
   input  wire logic irq_req,
   output logic      vector_ack,
   output logic      reti
);
   int   cnt;  // Cycles left in the current step.
   logic busy; // A request is being handled.
   logic isr;  // A routine is running.

   // A slow core lets the request re-pulse a few times before it answers.
   always @(posedge clk) begin
      vector_ack <= 1'b0;
      reti <= 1'b0;
      if (rst) begin
         busy <= 1'b0;
         isr <= 1'b0;
         cnt <= 0;
      end else if (!busy) begin
         busy <= irq_req;
         cnt <= slow ? 5 : 1;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else if (!isr) begin
         vector_ack <= 1'b1;
         isr <= 1'b1;
         cnt <= 6;
      end else begin
         reti <= 1'b1;
         isr <= 1'b0;
         busy <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** verif/irq_option_and_low_power_ctrl_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
// The driver queues each expected vector; the watcher checks every taken one.
module irq_option_and_low_power_ctrl_bench;
   // Design inputs, all given a value at time zero.
   logic        clk = 1'b0, rst = 1'b1, wr_en = 1'b0, exec_wait = 1'b0, exec_stop = 1'b0;
   logic        nmi_pin_n = 1'b1, port_a_irq_n = 1'b1, port_bc_irq = 1'b1;
   logic        timer_zero_flag = 1'b0, timer_irq_en = 1'b0, conv_done_flag = 1'b0;
   logic        conv_irq_en = 1'b0, watchdog_active = 1'b0, stop_with_watchdog_option = 1'b0;
   logic        backup_low_freq_osc = 1'b0, long_start_sel = 1'b0, slow = 1'b0;
   logic [7:0]  wr_addr = 8'h00, wr_data = 8'h00;
   // Design and core outputs.
   logic        irq_req, core_halt, osc_enable, periph_clk_en, watchdog_freeze;
   logic        use_backup_osc, vector_ack, reti;
   logic [11:0] irq_vector;
   logic [1:0]  power_mode;
   // Bench state.
   logic [11:0] exp_q[$];
   logic [7:0]  lfsr_val = 8'h42;
   int          miscompares = 0, num_checks = 0, cycles = 0, n, len;

   iolpc_ctrl dut (.clk, .rst, .wr_en, .wr_addr, .wr_data, .exec_wait, .exec_stop,
      .vector_ack, .reti, .nmi_pin_n, .port_a_irq_n, .port_bc_irq, .timer_zero_flag,
      .timer_irq_en, .conv_done_flag, .conv_irq_en, .watchdog_active,
      .stop_with_watchdog_option, .backup_low_freq_osc, .long_start_sel, .irq_req,
      .irq_vector, .core_halt, .osc_enable, .periph_clk_en, .watchdog_freeze,
      .use_backup_osc, .power_mode);
   iolpc_core_model core (.clk, .rst, .slow, .irq_req, .vector_ack, .reti);

   // 250 MHz clock.
   always #2 clk = ~clk;

   // Eight-bit shift register giving repeatable random bytes.
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask

   // Whole-byte write; the idle edge after it keeps strobes from colliding.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
      @(posedge clk);
      wr_en <= 1'b0;
      cyc(1);
   endtask

   // Falling pulse on port A, long enough to pass the synchroniser.
   task automatic pulse_a();
      @(posedge clk);
      port_a_irq_n <= 1'b0;
      cyc(5);
      port_a_irq_n <= 1'b1;
      cyc(5);
   endtask

   // Falling pulse on the NMI pin, same shape as the port A pulse.
   task automatic pulse_nmi();
      @(posedge clk);
      nmi_pin_n <= 1'b0;
      cyc(5);
      nmi_pin_n <= 1'b1;
      cyc(5);
   endtask

   // Issues WAIT or STOP, then settles so the mode can be sampled.
   task automatic exec(input logic stop);
      @(posedge clk);
      exec_stop <= stop;
      exec_wait <= ~stop;
      @(posedge clk);
      exec_stop <= 1'b0;
      exec_wait <= 1'b0;
      cyc(3);
      @(negedge clk);
   endtask

   // Bounded wait until at most k expected vectors remain.
   task automatic wait_q(input int k);
      int t;
      t = 0;
      while (exp_q.size() > k && t < 400) begin
         @(negedge clk);
         t++;
      end
      check({15'h0, exp_q.size() > k}, 16'h0000);
   endtask

   // Bounded wait for a power mode; n returns the cycles it took.
   task automatic wait_mode(input logic [1:0] m);
      n = 0;
      while (power_mode !== m && n < 40000) begin
         @(negedge clk);
         n++;
      end
      check({14'h0, power_mode}, {14'h0, m});
   endtask

   // Watcher: every vector the core takes must match the oldest note.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 45000) begin
         miscompares++;
         end_sim();
      end else if (!rst && vector_ack === 1'b1) begin
         if (exp_q.size() == 0)
            check(16'h0001, 16'h0000);
         else
            check({4'h0, irq_vector}, {4'h0, exp_q.pop_front()});
      end
   end

   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check({irq_vector, power_mode, core_halt, osc_enable},
            {iolpc_pkg::IOLPC_VEC_RESET, 4'h1});
      // Stray writes carry the enable bit; none may reach the option register.
      repeat (4) begin
         lfsr_val = lfsr(lfsr_val);
         wr(lfsr_val == 8'hC8 ? 8'hC9 : lfsr_val, lfsr_val | 8'h10);
      end
      timer_irq_en <= 1'b1;
      conv_irq_en <= 1'b1;
      timer_zero_flag <= 1'b1;
      pulse_a();
      pulse_a();
      port_bc_irq <= 1'b0;
      conv_done_flag <= 1'b1;
      slow <= 1'b1;
      cyc(20);
      // All four are pending; enabling must serve them strictly by priority.
      exp_q = {iolpc_pkg::IOLPC_VEC_EXT1, iolpc_pkg::IOLPC_VEC_EXT2,
               iolpc_pkg::IOLPC_VEC_TIMER, iolpc_pkg::IOLPC_VEC_CONV};
      wr(iolpc_pkg::IOLPC_OPT_ADDR, 8'h10);
      wait_q(1);
      @(posedge clk);
      timer_zero_flag <= 1'b0;
      wait_q(0);
      @(posedge clk);
      conv_done_flag <= 1'b0;
      slow <= 1'b0;
      cyc(10);
      // WAIT keeps clocks running; a rising edge on ports B/C wakes it.
      backup_low_freq_osc <= 1'b1;
      wr(iolpc_pkg::IOLPC_OPT_ADDR, 8'h30);
      exec(1'b0);
      check({11'h0, power_mode, core_halt, osc_enable, periph_clk_en},
            {11'h0, iolpc_pkg::IOLPC_WAIT, 3'h7});
      check({15'h0, use_backup_osc}, 16'h0001);
      exp_q.push_back(iolpc_pkg::IOLPC_VEC_EXT2);
      @(posedge clk);
      port_bc_irq <= 1'b1;
      wait_mode(iolpc_pkg::IOLPC_RUN);
      wait_q(0);
      cyc(10);
      // With the watchdog running and no permission, STOP acts as WAIT.
      watchdog_active <= 1'b1;
      exec(1'b1);
      check({14'h0, power_mode}, {14'h0, iolpc_pkg::IOLPC_WAIT});
      exp_q.push_back(iolpc_pkg::IOLPC_VEC_EXT1);
      pulse_a();
      wait_mode(iolpc_pkg::IOLPC_RUN);
      wait_q(0);
      cyc(10);
      // Permitted STOP: oscillator off, watchdog frozen, timer wakes, both start-up lengths.
      stop_with_watchdog_option <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         long_start_sel <= k[0];
         len = k ? iolpc_pkg::IOLPC_START_LONG : iolpc_pkg::IOLPC_START_SHORT;
         exec(1'b1);
         check({12'h0, power_mode, osc_enable, watchdog_freeze},
               {12'h0, iolpc_pkg::IOLPC_STOP, 2'b01});
         exp_q.push_back(iolpc_pkg::IOLPC_VEC_TIMER);
         @(posedge clk);
         timer_zero_flag <= 1'b1;
         wait_mode(iolpc_pkg::IOLPC_START);
         wait_mode(iolpc_pkg::IOLPC_RUN);
         check({15'h0, n >= len && n <= len + 8}, 16'h0001);
         wait_q(0);
         @(posedge clk);
         timer_zero_flag <= 1'b0;
         cyc(10);
      end
      // Level mode: a pin held low asks again after each return.
      exp_q = {iolpc_pkg::IOLPC_VEC_EXT1, iolpc_pkg::IOLPC_VEC_EXT1};
      wr(iolpc_pkg::IOLPC_OPT_ADDR, 8'h50);
      port_a_irq_n <= 1'b0;
      wait_q(0);
      @(posedge clk);
      port_a_irq_n <= 1'b1;
      cyc(10);
      // Disabled: NMI is still served in RUN but cannot end WAIT.
      wr(iolpc_pkg::IOLPC_OPT_ADDR, 8'h00);
      exp_q.push_back(iolpc_pkg::IOLPC_VEC_NMI);
      pulse_nmi();
      wait_q(0);
      cyc(10);
      exec(1'b0);
      pulse_nmi();
      @(negedge clk);
      check({14'h0, power_mode}, {14'h0, iolpc_pkg::IOLPC_WAIT});
      // A reset in mid-run ends WAIT and brings back the reset state.
      @(posedge clk);
      rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
      @(negedge clk);
      check({irq_vector, power_mode, core_halt, osc_enable},
            {iolpc_pkg::IOLPC_VEC_RESET, 4'h1});
      end_sim();
   end
endmodule
`default_nettype wire
